// ---- rtl/rsb_pkg.sv ----
// Purpose: shared constants and types of the reset strap and boot select block
// Assumes: straps are sampled on the rising edge of the active-low reset pin
// Notes: strap word layout is {ifSel[1:0], test, acSel[2:0]}
package rsb_pkg;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // fixed upper five bits of the default i2c slave address
  localparam logic [4:0] RSB_I2C_PREFIX = 5'h1D;
  localparam logic [2:0] RSB_AC_SKIP = 3'h3;
  localparam logic [2:0] RSB_AC_PROG = 3'h0;
  localparam logic [1:0] RSB_IF_PROG = 2'h3;
  localparam logic [1:0] RSB_IF_BOOT = 2'h3;
  localparam logic [7:0] RSB_EE_READ = 8'h03;
  // command byte plus 16-bit address, counted down to zero
  localparam logic [4:0] RSB_CMD_BITS = 5'h17;
  localparam logic [4:0] RSB_BYTE_BITS = 5'h07;
  localparam int RSB_LOAD_BYTES = 16;
  localparam int RSB_SCLK_HALF = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STRAP = 3'b000,
    ST_DECIDE = 3'b001,
    ST_ROM = 3'b010,
    ST_SPI_CMD = 3'b011,
    ST_SPI_DATA = 3'b100,
    ST_DONE = 3'b101
  } rsb_phase_t;

  typedef enum logic [1:0] {
    IF_I2C = 2'b00,
    IF_SPI_SLAVE = 2'b01,
    IF_SPI_BOOT = 2'b10
  } rsb_if_t;

  typedef struct packed {
    logic [1:0] ifSel;
    logic test;
    logic [2:0] acSel;
  } rsb_strap_t;

  typedef struct packed {
    logic [3:0] gpioOut;
    logic [3:0] gpioOe;
    logic csnOut;
    logic csnOe;
    logic sclkOut;
    logic sclkOe;
    logic sdaMosiOut;
    logic sdaMosiOe;
    logic misoOut;
    logic misoOe;
  } rsb_pin_out_t;

  typedef struct packed {
    rsb_phase_t phase;
    logic resetInPrev;
    rsb_strap_t status;
    rsb_if_t hostIf;
    logic testMode;
    logic progMode;
    logic skipAuto;
    logic [2:0] configIndex;
    logic [6:0] i2cAddr;
    logic [7:0] identFirst;
    logic [7:0] identSecond;
    logic romLoadReq;
    logic autoCfgDone;
    logic [7:0] cfgByte;
    logic cfgByteValid;
    logic [15:0] divCnt;
    logic sclkLvl;
    logic [4:0] bitCnt;
    logic [23:0] shift;
    logic [7:0] rxByte;
    logic [15:0] byteCnt;
    rsb_pin_out_t pins;
  } rsb_state_t;

endpackage

// ---- rtl/rsb_reset_strap_boot.sv ----
// Purpose: captures configuration straps at reset release and boots the device
// Assumes: all inputs synchronous to clk; resetInLow is the device reset pin
// Notes: the IF1 strap pad doubles as the MISO input while booting as spi master
//
// Behaviour
// - sample the six strap pins at the rising edge of the reset pin.
// - latch sampled straps into a readable strap capture status word.
// - after reset release the strap pins take their normal gpio, csn, miso role.
// - test strap high selects manufacturing test; config select picks the test mode.
// - internal eeprom variant, test 1, select 000, interface 11 allows eeprom programming.
// - test 1 with select 011 starts normally but skips auto-configuration; the code still raises testMode here.
// - config select straps give, in binary, the stored configuration 0 to 7.
// - rom variant: 00 and 01 give i2c slave, 10 spi slave, load from rom.
// - rom variant 11 boots as spi master from external eeprom, then spi slave.
// - as spi master the device sends command and address on mosi, then reads data on miso.
// - strap-chosen i2c address bits are defaults; an address write replaces them.
// - read-only 12-bit identification and 4-bit revision across two ident registers.
// - in i2c slave mode sda is a bidirectional line to the external master.
// - after spi master boot the csn pin becomes an input.
`timescale 1ns/1ns
module rsb_reset_strap_boot #(
  parameter bit INTERNAL_EEPROM = 1'b0,
  // identification values are arbitrary
  parameter logic [11:0] IDENT_CODE = 12'h5A3,
  parameter logic [3:0] REVISION = 4'h1,
  parameter int SCLK_HALF = rsb_pkg::RSB_SCLK_HALF,
  parameter int LOAD_BYTES = rsb_pkg::RSB_LOAD_BYTES
) (
  input logic clk,
  input logic rst,
  input logic resetInLow,
  input rsb_pkg::rsb_strap_t strapIn,
  input logic i2cAddrWr,
  input logic [6:0] i2cAddrWrData,
  input logic romLoadDone,
  input logic sdaDriveLow,
  input logic spiSlaveMiso,
  input logic spiSlaveMisoEn,
  input logic [3:0] gpioDrive,
  input logic [3:0] gpioDriveEn,
  output rsb_pkg::rsb_strap_t strapCaptureStatus,
  output logic testMode,
  output logic progMode,
  output logic skipAuto,
  output rsb_pkg::rsb_if_t hostIf,
  output logic [2:0] configIndex,
  output logic [6:0] i2cSlaveAddressReg,
  output logic [7:0] identRegFirst,
  output logic [7:0] identRegSecond,
  output logic romLoadReq,
  output logic autoCfgDone,
  output logic [7:0] cfgByte,
  output logic cfgByteValid,
  output rsb_pkg::rsb_pin_out_t pinOut
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [15:0] HALF_M1 = 16'(SCLK_HALF - 1);
  localparam logic [15:0] LAST_BYTE = 16'(LOAD_BYTES - 1);

  rsb_pkg::rsb_state_t state_q;
  rsb_pkg::rsb_state_t state_d;

  function automatic logic isSkip(input rsb_pkg::rsb_strap_t st);
    isSkip = st.test && (st.acSel == rsb_pkg::RSB_AC_SKIP);
  endfunction

  function automatic rsb_pkg::rsb_if_t decodeIf(input logic [1:0] sel);
    if (INTERNAL_EEPROM) begin
      decodeIf = (sel == rsb_pkg::RSB_IF_BOOT) ? rsb_pkg::IF_SPI_SLAVE : rsb_pkg::IF_I2C;
    end else begin
      case (sel)
        2'h0, 2'h1: decodeIf = rsb_pkg::IF_I2C;
        2'h2: decodeIf = rsb_pkg::IF_SPI_SLAVE;
        default: decodeIf = rsb_pkg::IF_SPI_BOOT;
      endcase
    end
  endfunction

  function automatic logic [15:0] eeAddr(input logic [2:0] idx);
    eeAddr = 16'(idx) * 16'(LOAD_BYTES);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.romLoadReq = 1'b0;
    state_d.cfgByteValid = 1'b0;
    state_d.resetInPrev = resetInLow;
    state_d.identFirst = IDENT_CODE[11:4];
    state_d.identSecond = {IDENT_CODE[3:0], REVISION};
    if (!resetInLow) begin
      state_d.phase = rsb_pkg::ST_STRAP;
      state_d.autoCfgDone = 1'b0;
      state_d.divCnt = '0;
      state_d.sclkLvl = 1'b0;
    end else begin
      case (state_q.phase)
        rsb_pkg::ST_STRAP: begin
          if (!state_q.resetInPrev) begin
            state_d.status = strapIn;
            state_d.phase = rsb_pkg::ST_DECIDE;
          end
        end
        rsb_pkg::ST_DECIDE: begin
          state_d.testMode = state_q.status.test;
          state_d.configIndex = state_q.status.acSel;
          state_d.skipAuto = isSkip(state_q.status);
          state_d.progMode = INTERNAL_EEPROM && state_q.status.test
            && (state_q.status.acSel == rsb_pkg::RSB_AC_PROG)
            && (state_q.status.ifSel == rsb_pkg::RSB_IF_PROG);
          state_d.hostIf = decodeIf(state_q.status.ifSel);
          state_d.i2cAddr = {rsb_pkg::RSB_I2C_PREFIX, state_q.status.ifSel};
          if (state_q.status.test) begin
            state_d.phase = rsb_pkg::ST_DONE;
            state_d.autoCfgDone = 1'b1;
          end else if (state_d.hostIf == rsb_pkg::IF_SPI_BOOT) begin
            state_d.phase = rsb_pkg::ST_SPI_CMD;
            state_d.shift = {rsb_pkg::RSB_EE_READ, eeAddr(state_q.status.acSel)};
            state_d.bitCnt = rsb_pkg::RSB_CMD_BITS;
            state_d.byteCnt = '0;
            state_d.divCnt = '0;
            state_d.sclkLvl = 1'b0;
          end else begin
            state_d.romLoadReq = 1'b1;
            state_d.phase = rsb_pkg::ST_ROM;
          end
        end
        rsb_pkg::ST_ROM: begin
          if (romLoadDone) begin
            state_d.phase = rsb_pkg::ST_DONE;
            state_d.autoCfgDone = 1'b1;
          end
        end
        rsb_pkg::ST_SPI_CMD, rsb_pkg::ST_SPI_DATA: begin
          if (state_q.divCnt == HALF_M1) begin
            state_d.divCnt = '0;
            state_d.sclkLvl = ~state_q.sclkLvl;
            if (!state_q.sclkLvl) begin
              // rising sclk: the IF1 pad now carries miso
              state_d.rxByte = {state_q.rxByte[6:0], strapIn.ifSel[1]};
            end else if (state_q.bitCnt != 5'h00) begin
              // next mosi bit on falling sclk
              state_d.bitCnt = state_q.bitCnt - 5'h01;
              state_d.shift = {state_q.shift[22:0], 1'b0};
            end else if (state_q.phase == rsb_pkg::ST_SPI_CMD) begin
              state_d.phase = rsb_pkg::ST_SPI_DATA;
              state_d.bitCnt = rsb_pkg::RSB_BYTE_BITS;
              state_d.shift = '0;
            end else begin
              state_d.cfgByte = state_q.rxByte;
              state_d.cfgByteValid = 1'b1;
              state_d.byteCnt = state_q.byteCnt + 16'h0001;
              state_d.bitCnt = rsb_pkg::RSB_BYTE_BITS;
              if (state_q.byteCnt == LAST_BYTE) begin
                // release csn, carry on as spi slave
                state_d.phase = rsb_pkg::ST_DONE;
                state_d.hostIf = rsb_pkg::IF_SPI_SLAVE;
                state_d.autoCfgDone = 1'b1;
                state_d.sclkLvl = 1'b0;
              end
            end
          end else begin
            state_d.divCnt = state_q.divCnt + 16'h0001;
          end
        end
        rsb_pkg::ST_DONE: begin
          state_d.phase = rsb_pkg::ST_DONE;
        end
        default: begin
          state_d.phase = rsb_pkg::ST_STRAP;
        end
      endcase
      // scripts or host may overwrite the address
      if (i2cAddrWr && (state_q.phase == rsb_pkg::ST_ROM || state_q.phase == rsb_pkg::ST_DONE)) begin
        state_d.i2cAddr = i2cAddrWrData;
      end
    end

    // pads stay released while straps are being read
    state_d.pins = '0;
    state_d.pins.csnOut = 1'b1;
    if (state_d.phase != rsb_pkg::ST_STRAP && state_d.phase != rsb_pkg::ST_DECIDE) begin
      state_d.pins.gpioOut = gpioDrive;
      state_d.pins.gpioOe = gpioDriveEn;
      if (state_d.phase == rsb_pkg::ST_SPI_CMD || state_d.phase == rsb_pkg::ST_SPI_DATA) begin
        // master drives csn, sclk and mosi
        state_d.pins.csnOut = 1'b0;
        state_d.pins.csnOe = 1'b1;
        state_d.pins.sclkOut = state_d.sclkLvl;
        state_d.pins.sclkOe = 1'b1;
        state_d.pins.sdaMosiOut = state_d.shift[23];
        state_d.pins.sdaMosiOe = 1'b1;
      end else if (state_d.hostIf == rsb_pkg::IF_I2C) begin
        // open-drain sda, only ever pulls low
        state_d.pins.sdaMosiOe = sdaDriveLow;
      end else if (state_d.hostIf == rsb_pkg::IF_SPI_SLAVE) begin
        state_d.pins.misoOut = spiSlaveMiso;
        state_d.pins.misoOe = spiSlaveMisoEn;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign strapCaptureStatus = state_q.status;
  assign testMode = state_q.testMode;
  assign progMode = state_q.progMode;
  assign skipAuto = state_q.skipAuto;
  assign hostIf = state_q.hostIf;
  assign configIndex = state_q.configIndex;
  assign i2cSlaveAddressReg = state_q.i2cAddr;
  assign identRegFirst = state_q.identFirst;
  assign identRegSecond = state_q.identSecond;
  assign romLoadReq = state_q.romLoadReq;
  assign autoCfgDone = state_q.autoCfgDone;
  assign cfgByte = state_q.cfgByte;
  assign cfgByteValid = state_q.cfgByteValid;
  assign pinOut = state_q.pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence decideNow;
    state_q.phase == rsb_pkg::ST_DECIDE && resetInLow;
  endsequence

  sequence bootStart;
    decideNow ##0 !state_q.status.test && !INTERNAL_EEPROM && state_q.status.ifSel == rsb_pkg::RSB_IF_BOOT;
  endsequence

  strap_capture_a: assert property (
    (state_q.phase == rsb_pkg::ST_STRAP && !state_q.resetInPrev && resetInLow)
    |=> state_q.status == $past(strapIn) && state_q.phase == rsb_pkg::ST_DECIDE)
    else $error("straps not captured at reset release");

  pins_released_a: assert property (
    !resetInLow |=> pinOut.gpioOe == 4'h0 && !pinOut.csnOe && !pinOut.misoOe && !pinOut.sdaMosiOe && !pinOut.sclkOe)
    else $error("strap pin driven during reset");

  test_mode_a: assert property (
    decideNow |=> testMode == $past(state_q.status.test) && configIndex == $past(state_q.status.acSel))
    else $error("test mode or selector wrong");

  prog_mode_a: assert property (
    decideNow |=> progMode == (INTERNAL_EEPROM && $past(state_q.status) == 6'h38))
    else $error("eeprom programming mode wrong");

  skip_load_a: assert property (
    decideNow ##0 isSkip(state_q.status) |=> state_q.phase == rsb_pkg::ST_DONE && !romLoadReq ##1 !romLoadReq)
    else $error("auto-configuration not skipped");

  rom_select_a: assert property (
    decideNow ##0 !state_q.status.test && !INTERNAL_EEPROM && state_q.status.ifSel != 2'h3
    |=> romLoadReq && hostIf == ($past(state_q.status.ifSel[1]) ? rsb_pkg::IF_SPI_SLAVE : rsb_pkg::IF_I2C)
        && i2cSlaveAddressReg == {rsb_pkg::RSB_I2C_PREFIX, $past(state_q.status.ifSel)})
    else $error("rom variant interface decode wrong");

  boot_master_a: assert property (
    bootStart |=> (state_q.phase == rsb_pkg::ST_SPI_CMD && pinOut.csnOe && !pinOut.csnOut
      && pinOut.sdaMosiOe && !pinOut.sdaMosiOut)[*2])
    else $error("spi master boot not started");

  csn_release_a: assert property (
    state_q.phase == rsb_pkg::ST_SPI_DATA ##1 state_q.phase == rsb_pkg::ST_DONE
    |-> !pinOut.csnOe && !pinOut.sclkOe && hostIf == rsb_pkg::IF_SPI_SLAVE && autoCfgDone)
    else $error("csn not released after boot");

  addr_write_a: assert property (
    i2cAddrWr && resetInLow && state_q.phase == rsb_pkg::ST_DONE |=> i2cSlaveAddressReg == $past(i2cAddrWrData))
    else $error("i2c address write lost");

  ident_value_a: assert property (
    state_q.phase == rsb_pkg::ST_DONE |-> identRegFirst == IDENT_CODE[11:4]
      && identRegSecond == {IDENT_CODE[3:0], REVISION})
    else $error("identification value wrong");

  sda_drive_a: assert property (
    state_q.phase == rsb_pkg::ST_DONE && hostIf == rsb_pkg::IF_I2C && resetInLow
    |=> pinOut.sdaMosiOe == $past(sdaDriveLow) && !pinOut.sdaMosiOut)
    else $error("sda open-drain drive wrong");

endmodule // rsb_reset_strap_boot

// ---- testbench/rsb_eeprom_model.sv ----
// Purpose: behavioural spi eeprom on the far side of the boot interface
// Assumes: mode 0, read command then a 16-bit address, msb first
// Notes: released pads read high through the board pull-ups
`timescale 1ns/1ns
module rsb_eeprom_model (
  input logic csnLine,
  input logic sclkLine,
  input logic mosiLine,
  output logic miso,
  output logic [7:0] cmdSeen,
  output logic [15:0] addrSeen
);
  int bitCnt = 0;
  int k;
  logic [23:0] rxShift = '0;
  logic outBit = 1'b1;
  logic [7:0] curByte;

  function automatic logic [7:0] eeData(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5C;
  endfunction

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  // select follows csn
  always @(posedge sclkLine or posedge csnLine) begin
    if (csnLine) begin
      bitCnt <= 0;
    end else begin
      if (bitCnt < 24) begin
        rxShift <= {rxShift[22:0], mosiLine};
      end
      bitCnt <= bitCnt + 1;
    end
  end
  assign cmdSeen = rxShift[23:16];
  assign addrSeen = rxShift[15:0];

  // ----------------------------------------------------------------
  // send side
  // ----------------------------------------------------------------
  // data moves on the falling edge so it is settled for the rising-edge sample
  always @(negedge sclkLine) begin
    if (!csnLine && bitCnt >= 24) begin
      k = bitCnt - 24;
      curByte = eeData(addrSeen + 16'(k / 8));
      outBit <= curByte[7 - (k % 8)];
    end
  end
  // deselected: the pull-up wins
  assign miso = csnLine ? 1'b1 : outBit;
endmodule // rsb_eeprom_model

// ---- testbench/rsb_reset_strap_boot_tb.sv ----
// Purpose: self-checking bench of the strap capture and boot block
// Assumes: rom variant under test, internal eeprom variant beside it
// Notes: every strap code is walked, then a few random ones
`timescale 1ns/1ns
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module rsb_reset_strap_boot_tb;
  localparam int LB = 2;
  // arbitrary identification values
  localparam logic [11:0] IDC = 12'hC3E;
  localparam logic [3:0] REV = 4'h9;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resetInLow = 1'b0;
  logic [5:0] strapDrv = '0;
  logic i2cAddrWr = 1'b0;
  logic [6:0] i2cAddrWrData = '0;
  logic romLoadDone = 1'b0;
  logic sdaDriveLow = 1'b0;
  logic spiSlaveMiso = 1'b0;
  logic spiSlaveMisoEn = 1'b0;
  logic [3:0] gpioDrive = '0;
  logic [3:0] gpioDriveEn = '0;
  rsb_pkg::rsb_strap_t strapIn, strapCaptureStatus;
  rsb_pkg::rsb_if_t hostIf, hostIf2;
  rsb_pkg::rsb_pin_out_t pinOut;
  logic testMode, progMode, skipAuto, progMode2, romLoadReq, autoCfgDone, cfgByteValid;
  logic [2:0] configIndex;
  logic [6:0] i2cAddr, i2cAddr2;
  logic [7:0] identFirst, identSecond, cfgByte, cmdSeen;
  logic [15:0] addrSeen;
  logic csnLine, sclkLine, mosiLine, eeMiso;
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  integer seed = 32'hB7D4;

  always #5 clk = ~clk;
  assign csnLine = pinOut.csnOe ? pinOut.csnOut : 1'b1;
  assign sclkLine = pinOut.sclkOe ? pinOut.sclkOut : 1'b1;
  assign mosiLine = pinOut.sdaMosiOe ? pinOut.sdaMosiOut : 1'b1;
  // the if1 strap pad carries miso while the eeprom is selected
  assign strapIn = rsb_pkg::rsb_strap_t'(csnLine ? strapDrv : {eeMiso, strapDrv[4:0]});

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  rsb_reset_strap_boot #(.INTERNAL_EEPROM(1'b0), .IDENT_CODE(IDC), .REVISION(REV), .SCLK_HALF(2),
    .LOAD_BYTES(LB)) rsb_reset_strap_boot_inst (.clk(clk), .rst(rst), .resetInLow(resetInLow),
    .strapIn(strapIn), .i2cAddrWr(i2cAddrWr), .i2cAddrWrData(i2cAddrWrData), .romLoadDone(romLoadDone),
    .sdaDriveLow(sdaDriveLow), .spiSlaveMiso(spiSlaveMiso), .spiSlaveMisoEn(spiSlaveMisoEn),
    .gpioDrive(gpioDrive), .gpioDriveEn(gpioDriveEn), .strapCaptureStatus(strapCaptureStatus),
    .testMode(testMode), .progMode(progMode), .skipAuto(skipAuto), .hostIf(hostIf),
    .configIndex(configIndex), .i2cSlaveAddressReg(i2cAddr), .identRegFirst(identFirst),
    .identRegSecond(identSecond), .romLoadReq(romLoadReq), .autoCfgDone(autoCfgDone),
    .cfgByte(cfgByte), .cfgByteValid(cfgByteValid), .pinOut(pinOut));
  rsb_reset_strap_boot #(.INTERNAL_EEPROM(1'b1), .SCLK_HALF(2), .LOAD_BYTES(LB)) rsb_reset_strap_boot_inst2 (
    .clk(clk), .rst(rst), .resetInLow(resetInLow), .strapIn(rsb_pkg::rsb_strap_t'(strapDrv)),
    .i2cAddrWr(i2cAddrWr), .i2cAddrWrData(i2cAddrWrData), .romLoadDone(romLoadDone),
    .sdaDriveLow(sdaDriveLow), .spiSlaveMiso(spiSlaveMiso), .spiSlaveMisoEn(spiSlaveMisoEn),
    .gpioDrive(gpioDrive), .gpioDriveEn(gpioDriveEn), .strapCaptureStatus(), .testMode(),
    .progMode(progMode2), .skipAuto(), .hostIf(hostIf2), .configIndex(), .i2cSlaveAddressReg(i2cAddr2),
    .identRegFirst(), .identRegSecond(), .romLoadReq(), .autoCfgDone(), .cfgByte(), .cfgByteValid(),
    .pinOut());
  rsb_eeprom_model rsb_eeprom_model_inst (.csnLine(csnLine), .sclkLine(sclkLine), .mosiLine(mosiLine),
    .miso(eeMiso), .cmdSeen(cmdSeen), .addrSeen(addrSeen));

  // ----------------------------------------------------------------
  // expectations and closing
  // ----------------------------------------------------------------
  function automatic logic [7:0] eeData(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5C;
  endfunction

  function automatic rsb_pkg::rsb_if_t expIf(input logic [5:0] s, input bit internal);
    if (internal) begin
      return (s[5:4] == 2'h3) ? rsb_pkg::IF_SPI_SLAVE : rsb_pkg::IF_I2C;
    end
    case (s[5:4])
      2'h0, 2'h1: return rsb_pkg::IF_I2C;
      2'h2: return rsb_pkg::IF_SPI_SLAVE;
      default: return rsb_pkg::IF_SPI_BOOT;
    endcase
  endfunction

  task automatic testDone();
    $display("compares %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      testDone();
    end
  end

  // ----------------------------------------------------------------
  // one boot with a given strap word, entered at a falling edge
  // ----------------------------------------------------------------
  task automatic runStrap(input logic [5:0] s);
    bit boot;
    int n;
    logic [6:0] a;
    boot = (s[3] == 1'b0) && (s[5:4] == 2'h3);
    resetInLow = 1'b0;
    strapDrv = s;
    repeat (3) @(negedge clk);
    resetInLow = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(strapCaptureStatus, s)
    `CHK(configIndex, s[2:0])
    `CHK(progMode, 1'b0)
    `CHK(progMode2, s == 6'h38)
    `CHK(hostIf2, expIf(s, 1'b1))
    if (s[2:0] != 3'h3) `CHK(testMode, s[3])
    if (!s[3] || s[2:0] == 3'h3) `CHK(skipAuto, s[3])
    if (!s[3] || s[5:4] != 2'h3) `CHK(hostIf, expIf(s, 1'b0))
    if (!s[5]) `CHK(i2cAddr, {rsb_pkg::RSB_I2C_PREFIX, s[5:4]})
    if (s[5:4] != 2'h3) `CHK(i2cAddr2, {rsb_pkg::RSB_I2C_PREFIX, s[5:4]})
    if (boot) begin
      n = 0;
      for (int c = 0; c < 3000 && autoCfgDone !== 1'b1; c++) begin
        @(negedge clk);
        if (cfgByteValid === 1'b1) begin
          `CHK(cfgByte, eeData(16'(s[2:0] * LB + n)))
          n++;
        end
      end
      `CHK(n, LB)
      `CHK(cmdSeen, rsb_pkg::RSB_EE_READ)
      `CHK(addrSeen, 16'(s[2:0] * LB))
      `CHK(hostIf, rsb_pkg::IF_SPI_SLAVE)
      `CHK(pinOut.csnOe, 1'b0)
    end else if (!s[3]) begin
      `CHK(romLoadReq, 1'b1)
      `CHK(autoCfgDone, 1'b0)
      romLoadDone = 1'b1;
      @(negedge clk);
      romLoadDone = 1'b0;
      `CHK(autoCfgDone, 1'b1)
    end else begin
      `CHK(romLoadReq, 1'b0)
      `CHK(autoCfgDone, 1'b1)
    end
    // pads in their normal role; straps moved to show they are ignored now
    gpioDrive = 4'($random(seed));
    gpioDriveEn = 4'($random(seed));
    sdaDriveLow = 1'($random(seed));
    spiSlaveMiso = 1'($random(seed));
    spiSlaveMisoEn = 1'($random(seed));
    a = 7'($random(seed));
    i2cAddrWrData = a;
    i2cAddrWr = !s[5];
    strapDrv = ~s;
    @(negedge clk);
    i2cAddrWr = 1'b0;
    `CHK(pinOut.gpioOut, gpioDrive)
    `CHK(pinOut.gpioOe, gpioDriveEn)
    `CHK(strapCaptureStatus, s)
    if (!s[5]) begin
      `CHK(pinOut.sdaMosiOe, sdaDriveLow)
      `CHK(pinOut.sdaMosiOut, 1'b0)
      `CHK(i2cAddr, a)
      `CHK(i2cAddr2, a)
    end
    if (s[5] && (!s[4] || boot)) begin
      `CHK(pinOut.misoOut, spiSlaveMiso)
      `CHK(pinOut.misoOe, spiSlaveMisoEn)
    end
    $display("strap word %0h finished", s);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK(identFirst, IDC[11:4])
    `CHK(identSecond, {IDC[3:0], REV})
    for (int i = 0; i < 64; i++) begin
      runStrap(6'(i));
    end
    repeat (8) runStrap(6'($random(seed)));
    testDone();
  end
endmodule // rsb_reset_strap_boot_tb
